// ===== core/arfc_pkg.sv
package arfc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_BBTIME   = 8'h04;
    localparam logic [7:0] OFS_WINDOW   = 8'h08;
    localparam logic [7:0] OFS_INTERVAL = 8'h0c;
    localparam logic [7:0] OFS_CMD      = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;
    // Control field positions
    localparam int LIM_LSB  = 0;
    localparam int LIM_MSB  = 3;
    localparam int FOS_BIT  = 4;
    localparam int MODE_BIT = 5;
    localparam int RT_LSB   = 6;
    localparam int RT_MSB   = 7;
    localparam int SS_LSB   = 8;
    localparam int SS_MSB   = 9;
    localparam int TF_LSB   = 16;
    localparam int TF_MSB   = 23;
    localparam int CMD_CLR  = 0;
    // Reset values and limits
    localparam logic [3:0]  LIMIT_MAX    = 4'ha;
    localparam logic [3:0]  LIMIT_RST    = 4'h0;
    localparam logic        FOS_RST      = 1'b0;
    localparam logic        MODE_RST     = 1'b1;
    localparam logic [1:0]  RT_RST       = 2'h0;
    localparam logic [1:0]  SS_RST       = 2'h0;
    localparam logic [7:0]  TF_RST       = 8'h00;
    localparam logic [7:0]  TF_RESTART   = 8'h1e;
    localparam logic [7:0]  TF_FAULT     = 8'h0e;
    localparam logic [15:0] BBTIME_RST   = 16'h0005;
    localparam logic [15:0] WINDOW_RST   = 16'h4650;
    localparam logic [15:0] WINDOW_MAX   = 16'hea60;
    localparam logic [15:0] INTERVAL_RST = 16'h0064;
    localparam logic [15:0] INTERVAL_MIN = 16'h0005;
    localparam logic [15:0] INTERVAL_MAX = 16'h1770;
    // Trip inputs, undervoltage position
    localparam int NTRIP  = 14;
    localparam int UV_IDX = 12;
    // Timebase: one tick is 10 ms
    localparam int    CLK_HZ      = 40_000_000;
    localparam int    TICK_MS     = 10;
    localparam int    TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
    localparam int    TENTH_TICKS = 100 / TICK_MS;
    localparam int    CLEAR_MIN   = 10;
    localparam int    CLEAR_TICKS = CLEAR_MIN * 60 * 1000 / TICK_MS;
    typedef enum logic [2:0] {
        ST_RUN, ST_BLOCK, ST_CHECK, ST_RESTART, ST_WAIT, ST_LOCK
    } arfc_state_t;
endpackage : arfc_pkg

// ===== core/arfc_top.sv
// What this block does
// - Restart limit register holds 0 to 10, reset value 0.
// - Reaching the limit stops the drive; fault stays latched until manual reset.
// - Ten minutes of fault-free running clears the restart count.
// - Manual fault clear after a trip clears the restart count.
// - Power cycle (reset) clears the restart count.
// - Block output for baseblock time, then restart only if fault gone.
// - Every restart forces a speed search from commanded speed.
// - In count-attempts mode each attempt that tried to rotate the motor counts, even failed.
// - No count when restart skipped because the fault persists.
// - Count-successful mode trips if no restart within retry window.
// - Count-successful mode waits after a failed attempt until the retry window ends, then trips.
// - Select bit decides whether fault output shows during restart.
// - Count-attempts mode spaces attempts by the programmed interval.
// - Mode 0 makes one attempt per trip, counting successful restarts up to limit.
// - Mode 1 counts attempts and stops once they reach the limit.
// - Only the listed trip kinds are eligible for automatic restart.
// - Undervoltage trip restarts only with power-loss ride-through enabled.
// - Terminal function 1E shows that automatic restart is possible.
`timescale 1ns/100ps
`default_nettype none
module arfc_top #(
    parameter int TICK_CYCLES = arfc_pkg::TICK_CYC
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_b_i,
    input  wire logic [7:0]                 paddr_i,
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [31:0]                pwdata_i,
    output logic      [31:0]                prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    input  wire logic [arfc_pkg::NTRIP-1:0] trip_i,
    input  wire logic                       other_trip_i,
    input  wire logic                       attempt_done_i,
    input  wire logic                       attempt_ok_i,
    input  wire logic                       fault_reset_pin_i,
    output logic                            output_block_o,
    output logic                            restart_cmd_o,
    output logic                            speed_search_o,
    output logic                            fault_relay_contact_o,
    output logic                            terminal_out_o,
    output logic                            drive_stop_o
);
    import arfc_pkg::*;

    // Configuration registers
    logic [3:0]  restart_limit;
    logic        restart_fault_output_sel;
    logic        restart_count_mode;
    logic [1:0]  power_loss_ridethru_sel;
    logic [1:0]  speed_search_sel;
    logic [7:0]  output_terminal_function_sel;
    logic [15:0] baseblock_time;
    logic [15:0] restart_retry_window;
    logic [15:0] restart_interval;

    // Sequencer state
    arfc_state_t state;
    arfc_state_t next_state;
    logic [3:0]  restart_count;
    logic [3:0]  next_restart_count;
    logic [31:0] pre_cnt;
    logic        tick;
    logic [19:0] wait_tmr;
    logic [19:0] next_wait_tmr;
    logic [15:0] win_tmr;
    logic [15:0] next_win_tmr;
    logic [15:0] clr_tmr;
    logic [2:0]  rst_pin_sync;
    logic        rst_pin_seen;

    // Tenths of a second to ticks, used for the baseblock time and the restart interval
    function automatic logic [19:0] tenths(input logic [15:0] v);
        tenths = 20'(v) * 20'(TENTH_TICKS);
    endfunction : tenths

    // Clamp a value into a range, shared by register writes
    function automatic logic [15:0] clamp(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp

    // APB decode
    wire setup_ph  = psel_i & ~penable_i;
    wire access_ph = psel_i & penable_i & pready_o;
    wire wr_en     = access_ph & pwrite_i;
    wire hit_ctrl  = paddr_i == OFS_CTRL;
    wire hit_bb    = paddr_i == OFS_BBTIME;
    wire hit_win   = paddr_i == OFS_WINDOW;
    wire hit_int   = paddr_i == OFS_INTERVAL;
    wire hit_cmd   = paddr_i == OFS_CMD;
    wire hit_stat  = paddr_i == OFS_STATUS;
    wire mapped    = hit_ctrl | hit_bb | hit_win | hit_int | hit_cmd | hit_stat;
    wire sw_clear  = wr_en & hit_cmd & pwdata_i[CMD_CLR];
    wire [3:0] lim_wr = pwdata_i[LIM_MSB:LIM_LSB];

    // Read mux; command register reads as zero
    wire [31:0] ctrl_rd = {8'h00, output_terminal_function_sel, 6'h00,
                           speed_search_sel, power_loss_ridethru_sel,
                           restart_count_mode, restart_fault_output_sel,
                           restart_limit};
    wire [31:0] stat_rd = {21'h000000, drive_stop_o, 3'(state),
                           restart_count, 3'h0};
    wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd :
                          hit_bb   ? {16'h0000, baseblock_time} :
                          hit_win  ? {16'h0000, restart_retry_window} :
                          hit_int  ? {16'h0000, restart_interval} :
                          hit_stat ? stat_rd : 32'h00000000;

    // No wait states: data is registered in setup, ready in access
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= setup_ph;
            pslverr_o <= setup_ph & ~mapped;
            if (setup_ph) begin
                prdata_o <= pwrite_i ? 32'h00000000 : rd_mux;
            end
        end
    end

    // Register writes; out-of-range settings are clamped
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            restart_limit                <= LIMIT_RST;
            restart_fault_output_sel     <= FOS_RST;
            restart_count_mode           <= MODE_RST;
            power_loss_ridethru_sel      <= RT_RST;
            speed_search_sel             <= SS_RST;
            output_terminal_function_sel <= TF_RST;
            baseblock_time               <= BBTIME_RST;
            restart_retry_window         <= WINDOW_RST;
            restart_interval             <= INTERVAL_RST;
        end else if (wr_en) begin
            if (hit_ctrl) begin
                restart_limit <= (lim_wr > LIMIT_MAX) ? LIMIT_MAX : lim_wr;
                restart_fault_output_sel     <= pwdata_i[FOS_BIT];
                restart_count_mode           <= pwdata_i[MODE_BIT];
                power_loss_ridethru_sel      <= pwdata_i[RT_MSB:RT_LSB];
                speed_search_sel             <= pwdata_i[SS_MSB:SS_LSB];
                output_terminal_function_sel <= pwdata_i[TF_MSB:TF_LSB];
            end
            if (hit_bb) begin
                baseblock_time <= pwdata_i[15:0];
            end
            if (hit_win) begin
                restart_retry_window <= clamp(pwdata_i[15:0], 16'h0000, WINDOW_MAX);
            end
            if (hit_int) begin
                restart_interval <= clamp(pwdata_i[15:0], INTERVAL_MIN, INTERVAL_MAX);
            end
        end
    end

    // Reset pin from the terminal strip: three stages, act when 2nd and 3rd agree
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_pin_sync <= 3'h0;
            rst_pin_seen <= 1'b0;
        end else begin
            rst_pin_sync <= {rst_pin_sync[1:0], fault_reset_pin_i};
            if (rst_pin_sync[2] == rst_pin_sync[1]) begin
                rst_pin_seen <= rst_pin_sync[1];
            end
        end
    end
    wire pin_clear    = rst_pin_sync[2] & rst_pin_sync[1] & ~rst_pin_seen;
    wire manual_clear = sw_clear | pin_clear;

    // 10 ms timebase; a long count, so the top parameter can shorten it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_cnt <= 32'h00000000;
            tick    <= 1'b0;
        end else begin
            tick    <= pre_cnt == 32'(TICK_CYCLES - 1);
            pre_cnt <= (pre_cnt == 32'(TICK_CYCLES - 1)) ? 32'h00000000 : pre_cnt + 32'h1;
        end
    end

    // Trip qualification
    wire uv_ok      = power_loss_ridethru_sel != 2'h0;
    wire [NTRIP-1:0] elig_mask = {{(NTRIP-1-UV_IDX){1'b1}}, uv_ok, {UV_IDX{1'b1}}};
    wire elig_trip  = |(trip_i & elig_mask);
    wire any_trip   = (|trip_i) | other_trip_i;
    wire bad_trip   = other_trip_i | (|(trip_i & ~elig_mask));
    wire at_limit   = restart_count >= restart_limit;
    wire wait_done  = wait_tmr == 20'h00000;
    wire win_done   = win_tmr == 16'h0000;
    // Gap after a failed or skipped attempt depends on counting mode
    wire [19:0] gap = restart_count_mode ? tenths(restart_interval)
                                         : 20'(restart_retry_window);

    // Sequencer next state
    always_comb begin
        next_state         = state;
        next_restart_count = restart_count;
        next_wait_tmr      = (tick && !wait_done) ? wait_tmr - 20'h1 : wait_tmr;
        next_win_tmr       = (tick && !win_done) ? win_tmr - 16'h1 : win_tmr;
        unique case (state)
            ST_RUN: begin
                if (any_trip) begin
                    if (bad_trip || !elig_trip || at_limit) begin
                        next_state = ST_LOCK;
                    end else begin
                        next_state    = ST_BLOCK;
                        next_wait_tmr = tenths(baseblock_time);
                        next_win_tmr  = restart_retry_window;
                    end
                end
            end
            ST_BLOCK: begin
                if (wait_done) begin
                    next_state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (bad_trip) begin
                    next_state = ST_LOCK;
                end else if (elig_trip) begin
                    // Fault persists: no attempt, so no count
                    if (!restart_count_mode && win_done) begin
                        next_state = ST_LOCK;
                    end else if (restart_count_mode) begin
                        next_state    = ST_WAIT;
                        next_wait_tmr = gap;
                    end
                end else if (at_limit) begin
                    next_state = ST_LOCK;
                end else begin
                    next_state = ST_RESTART;
                    if (restart_count_mode) begin
                        next_restart_count = restart_count + 4'h1;
                    end
                end
            end
            ST_RESTART: begin
                if (attempt_done_i) begin
                    if (attempt_ok_i) begin
                        next_state = ST_RUN;
                        if (!restart_count_mode) begin
                            next_restart_count = restart_count + 4'h1;
                        end
                    end else begin
                        next_state    = ST_WAIT;
                        next_wait_tmr = gap;
                    end
                end
            end
            ST_WAIT: begin
                if (!restart_count_mode && win_done) begin
                    next_state = ST_LOCK;
                end else if (wait_done) begin
                    next_state    = ST_BLOCK;
                    next_wait_tmr = tenths(baseblock_time);
                end
            end
            ST_LOCK: begin
                if (manual_clear) begin
                    next_state = ST_RUN;
                end
            end
        endcase
        // Manual clear after a trip always empties the count
        if (manual_clear && state != ST_RUN) begin
            next_restart_count = 4'h0;
        end
    end

    // Quiet-run timer: the clear of a count is lost if any trip appears
    wire clr_full = clr_tmr == 16'(CLEAR_TICKS);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clr_tmr <= 16'h0000;
        end else if (state != ST_RUN || any_trip || restart_count == 4'h0) begin
            clr_tmr <= 16'h0000;
        end else if (tick && !clr_full) begin
            clr_tmr <= clr_tmr + 16'h1;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state         <= ST_RUN;
            restart_count <= 4'h0;
            wait_tmr      <= 20'h00000;
            win_tmr       <= 16'h0000;
        end else begin
            state         <= next_state;
            wait_tmr      <= next_wait_tmr;
            win_tmr       <= next_win_tmr;
            restart_count <= (clr_full && state == ST_RUN) ? 4'h0
                                                            : next_restart_count;
        end
    end

    // Output decode; all pins registered below
    wire in_restart  = next_state == ST_RESTART;
    wire in_seq      = next_state != ST_RUN && next_state != ST_LOCK;
    wire locked      = next_state == ST_LOCK;
    wire fault_shown = locked | (in_seq & restart_fault_output_sel);
    wire can_restart = in_seq & ~at_limit;
    wire term_val    = (output_terminal_function_sel == TF_RESTART) ? can_restart :
                       (output_terminal_function_sel == TF_FAULT) ? fault_shown : 1'b0;

    // Speed search is forced whatever the search selection holds
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            output_block_o        <= 1'b0;
            restart_cmd_o         <= 1'b0;
            speed_search_o        <= 1'b0;
            fault_relay_contact_o <= 1'b0;
            terminal_out_o        <= 1'b0;
            drive_stop_o          <= 1'b0;
        end else begin
            output_block_o        <= next_state != ST_RUN && !in_restart;
            restart_cmd_o         <= in_restart;
            speed_search_o        <= in_restart;
            fault_relay_contact_o <= fault_shown;
            terminal_out_o        <= term_val;
            drive_stop_o          <= locked;
        end
    end
endmodule : arfc_top
`default_nettype wire

// ===== tb/arfc_motor_model.sv
`timescale 1ns/100ps
`default_nettype none
module arfc_motor_model (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic restart_cmd_i,
    input  wire logic ok_sel_i,
    output logic      attempt_done_o,
    output logic      attempt_ok_o
);
    logic [3:0] spin_cnt;
    wire logic  fire = restart_cmd_i && spin_cnt == 4'h6;
    // Spin up for some cycles, report once; ok toggles when not qualified
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            spin_cnt <= 4'h0;
            attempt_done_o <= 1'b0;
            attempt_ok_o <= 1'b0;
        end else begin
            attempt_done_o <= fire;
            attempt_ok_o <= fire ? ok_sel_i : ~attempt_ok_o;
            // Run withdrawn while output is cut; spins only on restart
            spin_cnt <= (restart_cmd_i && !attempt_done_o) ? spin_cnt + 4'h1 : 4'h0;
        end
    end
endmodule : arfc_motor_model
`default_nettype wire

// ===== tb/arfc_props.sv
`timescale 1ns/100ps
`default_nettype none
module arfc_props (
    input wire logic                       clk_i,
    input wire logic                       rst_b_i,
    input wire logic                       psel_i,
    input wire logic                       penable_i,
    input wire logic                       pready_o,
    input wire logic [arfc_pkg::NTRIP-1:0] trip_i,
    input wire logic                       other_trip_i,
    input wire logic                       attempt_done_i,
    input wire logic                       attempt_ok_i,
    input wire logic                       output_block_o,
    input wire logic                       restart_cmd_o,
    input wire logic                       speed_search_o,
    input wire logic                       fault_relay_contact_o,
    input wire logic                       drive_stop_o
);
    import arfc_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Running normally; undervoltage left out since it depends on ride-through
    wire logic idle = !output_block_o && !restart_cmd_o && !drive_stop_o;
    wire logic elig = |{trip_i[13], trip_i[11:0]};

    a_reset_quiet: assert property ($rose(rst_b_i) |-> !output_block_o && !restart_cmd_o
        && !drive_stop_o) else $error("outputs active after reset");
    a_search_follows: assert property (speed_search_o == restart_cmd_o)
        else $error("speed search differs from restart");
    a_lock_holds: assert property (drive_stop_o |-> output_block_o && fault_relay_contact_o
        && !restart_cmd_o) else $error("lock without block and fault");
    a_trip_blocks: assert property (idle && elig |=> output_block_o)
        else $error("eligible trip did not block output");
    a_foreign_locks: assert property (idle && other_trip_i |-> ##[1:2] drive_stop_o)
        else $error("non-eligible trip did not stop drive");
    a_no_restart_trip: assert property ($rose(restart_cmd_o) |-> $past(trip_i) == '0)
        else $error("restart while fault persists");
    a_done_ends: assert property (restart_cmd_o && attempt_done_i && attempt_ok_i
        |=> !restart_cmd_o && !output_block_o) else $error("success did not end restart");
    a_pready_once: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
        else $error("pready not a single access cycle");

    c_restart: cover property ($rose(restart_cmd_o));
    c_lock: cover property ($rose(drive_stop_o));
    c_failed: cover property (restart_cmd_o && attempt_done_i && !attempt_ok_i);
endmodule : arfc_props
bind arfc_top arfc_props u_props (.clk_i, .rst_b_i, .psel_i, .penable_i, .pready_o, .trip_i,
    .other_trip_i, .attempt_done_i, .attempt_ok_i, .output_block_o, .restart_cmd_o,
    .speed_search_o, .fault_relay_contact_o, .drive_stop_o);
`default_nettype wire

// ===== tb/test_auto_fault_restart_control.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module test_auto_fault_restart_control;
    import arfc_pkg::*;
    typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;}
        arfc_row_t;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [13:0] trip = 14'h0;
    logic        other_trip = 1'b0;
    logic        frst = 1'b0;
    logic        ok_sel = 1'b1;
    logic [31:0] prdata, q;
    logic        pready, pslverr, done, ok, blk, rcmd, ss, relay, term, stop, e;
    int          fails = 0;
    int          cmp_count = 0;
    // Reads of reset values, clamps and an unmapped place
    arfc_row_t rows[12] = '{
        '{1'b0, OFS_CTRL, 32'h0, 32'h20, 1'b0}, '{1'b0, OFS_BBTIME, 32'h0, 32'h5, 1'b0},
        '{1'b0, OFS_WINDOW, 32'h0, 32'h4650, 1'b0}, '{1'b0, OFS_INTERVAL, 32'h0, 32'h64, 1'b0},
        '{1'b0, OFS_STATUS, 32'h0, 32'h0, 1'b0}, '{1'b1, OFS_CTRL, 32'h2f, 32'h0, 1'b0},
        '{1'b0, OFS_CTRL, 32'h0, 32'h2a, 1'b0}, '{1'b1, OFS_INTERVAL, 32'h1, 32'h0, 1'b0},
        '{1'b0, OFS_INTERVAL, 32'h0, 32'h5, 1'b0}, '{1'b1, OFS_INTERVAL, 32'h1771, 32'h0, 1'b0},
        '{1'b0, OFS_INTERVAL, 32'h0, 32'h1770, 1'b0}, '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1}};

    // One-cycle tick so the ten-minute clear fits inside the run
    arfc_top #(.TICK_CYCLES(1)) u_dut (.clk_i(clk), .rst_b_i(rst_b), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .trip_i(trip),
        .other_trip_i(other_trip), .attempt_done_i(done), .attempt_ok_i(ok),
        .fault_reset_pin_i(frst), .output_block_o(blk), .restart_cmd_o(rcmd),
        .speed_search_o(ss), .fault_relay_contact_o(relay), .terminal_out_o(term),
        .drive_stop_o(stop));
    arfc_motor_model u_motor (.clk_i(clk), .rst_b_i(rst_b), .restart_cmd_i(rcmd),
        .ok_sel_i(ok_sel), .attempt_done_o(done), .attempt_ok_o(ok));

    // Clock at 40 MHz
    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic re);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        if (pready !== 1'b1) begin
            fails++;
            $display("MISMATCH pready expected 1 seen %b", pready);
        end
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic stat(input logic [3:0] n);
        apb(1'b0, OFS_STATUS, 32'h0, q, e);
        `CHK("restart count", n, q[6:3])
    endtask : stat

    task automatic pulse(input int i);
        trip[i] <= 1'b1;
        @(posedge clk);
        trip[i] <= 1'b0;
    endtask : pulse

    // Bounded wait for a level on a design output
    task automatic await(ref logic s, input logic v, input int lim, input string nm);
        int n;
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        `CHK(nm, v, s)
    endtask : await

    // Watchdog, above the 60000-cycle quiet-run clear plus the rest
    initial begin
        repeat (90000) @(posedge clk);
        fails++;
        end_of_test();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d, q, e);
            `CHK("pslverr", rows[i].e, e)
            if (!rows[i].wr) `CHK("prdata", rows[i].q, q)
        end
        $display("test registers done");
        // Limit 2, fault output on, count attempts, terminal shows restart
        wr(OFS_CTRL, 32'h001e0032);
        wr(OFS_BBTIME, 32'h1);
        wr(OFS_INTERVAL, 32'h5);
        pulse(0);
        await(rcmd, 1'b1, 500, "restart");
        `CHK("speed search", 1'b1, ss)
        `CHK("fault relay", 1'b1, relay)
        `CHK("terminal", 1'b1, term)
        await(rcmd, 1'b0, 50, "restart end");
        stat(4'h1);
        $display("test good restart done");
        // Fault persists through block and check; motor fails the attempt
        ok_sel <= 1'b0;
        trip[3] <= 1'b1;
        repeat (300) @(posedge clk);
        `CHK("restart held", 1'b0, rcmd)
        stat(4'h1);
        trip[3] <= 1'b0;
        await(rcmd, 1'b1, 1000, "late restart");
        stat(4'h2);
        await(stop, 1'b1, 2000, "lock at limit");
        $display("test persistent fault done");
        frst <= 1'b1;
        await(stop, 1'b0, 20, "manual clear");
        frst <= 1'b0;
        stat(4'h0);
        $display("test manual clear done");
        // Undervoltage without ride-through locks; with it, restart runs
        ok_sel <= 1'b1;
        pulse(12);
        await(stop, 1'b1, 20, "undervoltage lock");
        wr(OFS_CMD, 32'h1);
        `CHK("command clear", 1'b0, stop)
        wr(OFS_CTRL, 32'h001e0062);
        pulse(12);
        await(rcmd, 1'b1, 500, "undervoltage restart");
        `CHK("fault relay off", 1'b0, relay)
        await(rcmd, 1'b0, 50, "restart end");
        $display("test undervoltage done");
        // Count-successful mode: a held fault holds off the restart until the window ends, then locks
        wr(OFS_CTRL, 32'h000e0012);
        wr(OFS_WINDOW, 32'h64);
        trip[1] <= 1'b1;
        await(stop, 1'b1, 300, "window lock");
        stat(4'h1);
        trip[1] <= 1'b0;
        wr(OFS_CMD, 32'h1);
        pulse(1);
        await(rcmd, 1'b1, 200, "restart");
        `CHK("terminal fault", 1'b1, term)
        stat(4'h0);
        await(rcmd, 1'b0, 50, "restart end");
        stat(4'h1);
        repeat (60010) @(posedge clk);
        stat(4'h0);
        $display("test count-successful mode done");
        other_trip <= 1'b1;
        @(posedge clk);
        other_trip <= 1'b0;
        await(stop, 1'b1, 20, "foreign trip");
        wr(OFS_CMD, 32'h1);
        wr(OFS_CTRL, 32'h001e0020);
        pulse(5);
        await(stop, 1'b1, 20, "limit zero");
        wr(OFS_CMD, 32'h1);
        $display("test lock cases done");
        // Power cycle in mid-restart clears count and sequence
        wr(OFS_CTRL, 32'h001e0022);
        pulse(0);
        await(rcmd, 1'b1, 500, "restart");
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        `CHK("restart after reset", 1'b0, rcmd)
        stat(4'h0);
        $display("test power cycle done");
        end_of_test();
    end
endmodule : test_auto_fault_restart_control
`default_nettype wire
